/* include/pin_change_consts.vh */
/*
 Constants for the pin-change edge interrupt block: register offsets,
 field positions, reset values and bus response codes.
 Assumes it is included by bare name from the design file.
*/
`ifndef PIN_CHANGE_CONSTS_VH
`define PIN_CHANGE_CONSTS_VH

`define OFS_PORTA_RISE 8'h00
`define OFS_PORTA_FALL 8'h04
`define OFS_PORTA_FLAGS 8'h08
`define OFS_PORTB_RISE 8'h0C
`define OFS_PORTB_FALL 8'h10
`define OFS_PORTB_FLAGS 8'h14
`define OFS_PORTC_RISE 8'h18
`define OFS_PORTC_FALL 8'h1C
`define OFS_PORTC_FLAGS 8'h20
`define OFS_CONTROL 8'h24
`define OFS_IRQ_STATUS 8'h28
`define OFS_IRQ_MASK 8'h2C
`define PORT_STRIDE 8'h0C

`define CTRL_MASTER_EN_BIT 0
`define CTRL_SLEEP_BIT 1
`define STAT_SUMMARY_BIT 0

`define RST_BYTE 8'h00
`define RST_BIT 1'b0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define ADDR_LO_ZERO 2'h0

`endif

/* hdl/pin_change_edge_interrupt.v */
/*
 Pin-change edge interrupt logic for three 8-bit ports with an AXI4-Lite
 register slave, a summary flag, a masked interrupt and a sleep wake request.
 Assumes pins are already synchronous to i_clk and one AXI4-Lite master.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pin_change_consts.vh"

module pin_change_edge_interrupt #(
    parameter PORT_WIDTH = 8,
    parameter ADDR_WIDTH = 8
) (
    // clock and reset
    input wire i_clk,
    input wire i_rst,
    // port pins
    input wire [PORT_WIDTH-1:0] i_porta_pin,
    input wire [PORT_WIDTH-1:0] i_portb_pin,
    input wire [PORT_WIDTH-1:0] i_portc_pin,
    // axi4-lite write address
    input wire [ADDR_WIDTH-1:0] i_s_axi_awaddr,
    input wire i_s_axi_awvalid,
    output reg o_s_axi_awready,
    // axi4-lite write data
    input wire [31:0] i_s_axi_wdata,
    input wire [3:0] i_s_axi_wstrb,
    input wire i_s_axi_wvalid,
    output reg o_s_axi_wready,
    // axi4-lite write response
    output reg [1:0] o_s_axi_bresp,
    output reg o_s_axi_bvalid,
    input wire i_s_axi_bready,
    // axi4-lite read address
    input wire [ADDR_WIDTH-1:0] i_s_axi_araddr,
    input wire i_s_axi_arvalid,
    output reg o_s_axi_arready,
    // axi4-lite read data
    output reg [31:0] o_s_axi_rdata,
    output reg [1:0] o_s_axi_rresp,
    output reg o_s_axi_rvalid,
    input wire i_s_axi_rready,
    // interrupt and wake
    output reg o_irq,
    output reg o_pin_change_summary_flag,
    output reg o_wake
);

    localparam NPORT = 3;
    localparam NPIN = NPORT * PORT_WIDTH;

    // ----------------------------------------
    // operating notes
    // ----------------------------------------
    // pin path
    // - pins arrive already synchronous to i_clk
    // - one stage of history per pin in pin_prev
    // - rise: pin now high, last sample low
    // - fall: pin now low, last sample high
    // - each edge is seen for exactly one cycle
    // - a level held high sets nothing further
    // - history loads the live pins during reset
    // - so a pin high at release gives no false rise
    // - a pulse shorter than one clock may be missed
    // - a user needing glitch capture must stretch it
    //
    // enables
    // - rise and fall enables are separate bits
    // - both may be set on the same pin
    // - with both clear the pin is ignored
    // - enables act on the edge, not on the level
    // - writing an enable never sets a flag itself
    //
    // flags
    // - one sticky bit per pin, set by hardware
    // - software clears by writing zero
    // - a written one also sets the bit
    // - an edge in the write cycle wins over the write
    // - so a masked clear never loses a new edge
    // - flags keep collecting with master enable off
    //
    // summary
    // - or of all flags of all ports
    // - registered, one cycle behind the flags
    // - drops once every flag is cleared
    //
    // interrupt
    // - status bit records a rising summary
    // - status clears on a written one
    // - a new summary rise in the same cycle wins
    // - o_irq follows the summary level
    // - o_irq is gated by master enable and mask
    // - with master enable off no interrupt leaves
    //
    // sleep and wake
    // - software sets the sleep bit in control
    // - any set flag with master enable ends sleep
    // - sleep bit clears itself on that cycle
    // - o_wake is high for one cycle only
    // - the flag is already set when wake rises
    // - so the first fetch after wake sees the flag
    // - sleep with a flag already set wakes at once
    // - a user should clear flags before sleeping
    //
    // register bus
    // - axi4-lite slave, one write and one read at a time
    // - address and data may come in either order
    // - each is parked in its own holding slot
    // - the write lands when both slots are full and no write response is pending
    // - response rises on the same edge the write lands
    // - ready stays low after a handshake until its slot or read response clears
    // - that costs bandwidth but needs no skid buffer
    // - read data are answered one cycle after address
    // - read data stand until the master takes them
    //
    // register map
    // - byte addresses, one word per register
    // - port a, port b, port c in that order
    // - each port: rise enable, fall enable, flags
    // - then control, interrupt status, mask
    // - only byte lane 0 carries meaning
    // - a write without lane 0 is acknowledged, ignored
    // - upper bits read as zero
    //
    // errors
    // - unmapped address: slave error, no effect
    // - unaligned address: slave error, no effect
    // - read error data are zero
    //
    // reset
    // - synchronous, active high
    // - every enable, flag and control bit to zero
    // - readies low during reset
    // - readies rise on the first edge after release
    //
    // limits
    // - no analog or direction setup in this block
    // - no single-pin port beyond a, b and c
    // - the interrupt controller sits outside
    // - the wake line only requests; the core decides
    //
    // timing from a pin edge
    // - edge k: pin change seen, flag set
    // - edge k+1: summary and wake rise
    // - edge k+1: interrupt status set as well
    // - a read after that returns the flag
    //
    // widths
    // - port width is a parameter, default eight
    // - register fields assume it fits byte lane 0
    // - address width is a parameter, default eight
    //
    // hazards
    // - a read racing a flag set may miss that edge
    // - the flag is still set; the next read sees it
    // - clearing with a plain zero write can drop
    //   an edge seen between the read and the write
    // - use a masked clear of known bits instead

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg [NPIN-1:0] rise_enable;
    reg [NPIN-1:0] fall_enable;
    reg [NPIN-1:0] change_flags;
    reg [NPIN-1:0] pin_prev;
    reg pin_change_master_enable;
    reg sleep_mode;
    reg irq_status;
    reg irq_mask;

    // bus state
    reg aw_held;
    reg w_held;
    reg [ADDR_WIDTH-1:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;

    wire [NPIN-1:0] pin_now = {i_portc_pin, i_portb_pin, i_porta_pin};

    // ----------------------------------------
    // edge detection
    // ----------------------------------------
    wire [NPIN-1:0] rise_seen = pin_now & ~pin_prev & rise_enable;
    wire [NPIN-1:0] fall_seen = ~pin_now & pin_prev & fall_enable;
    wire [NPIN-1:0] edge_hit = rise_seen | fall_seen;

    always @(posedge i_clk) begin
        if (i_rst) begin
            // load live pins so no false edge follows reset
            pin_prev <= pin_now;
        end else begin
            pin_prev <= pin_now;
        end
    end

    // ----------------------------------------
    // axi4-lite write path
    // ----------------------------------------
    wire wr_go = aw_held && w_held && !o_s_axi_bvalid;
    wire [ADDR_WIDTH-1:0] wa = aw_addr;
    wire wa_aligned = (wa[1:0] == `ADDR_LO_ZERO);
    wire lane0 = w_strb[0];

    reg wr_map;
    always @* begin
        case (wa)
            `OFS_PORTA_RISE, `OFS_PORTA_FALL, `OFS_PORTA_FLAGS,
            `OFS_PORTB_RISE, `OFS_PORTB_FALL, `OFS_PORTB_FLAGS,
            `OFS_PORTC_RISE, `OFS_PORTC_FALL, `OFS_PORTC_FLAGS,
            `OFS_CONTROL, `OFS_IRQ_STATUS, `OFS_IRQ_MASK: wr_map = wa_aligned;
            default: wr_map = 1'b0;
        endcase
    end

    wire do_wr = wr_go && wr_map && lane0;

    always @(posedge i_clk) begin
        if (i_rst) begin
            o_s_axi_awready <= 1'b0;
            o_s_axi_wready <= 1'b0;
            o_s_axi_bvalid <= 1'b0;
            o_s_axi_bresp <= `RESP_OKAY;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= {ADDR_WIDTH{1'b0}};
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else begin
            // ready only while the holding slot is empty; no skid buffer needed
            o_s_axi_awready <= !aw_held && !(i_s_axi_awvalid && o_s_axi_awready);
            o_s_axi_wready <= !w_held && !(i_s_axi_wvalid && o_s_axi_wready);
            if (i_s_axi_awvalid && o_s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= i_s_axi_awaddr;
            end
            if (i_s_axi_wvalid && o_s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= i_s_axi_wdata;
                w_strb <= i_s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                o_s_axi_bvalid <= 1'b1;
                o_s_axi_bresp <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
            end else if (o_s_axi_bvalid && i_s_axi_bready) begin
                o_s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // per-port registers and flags
    // ----------------------------------------
    genvar p;
    generate
        for (p = 0; p < NPORT; p = p + 1) begin : g_port
            wire [31:0] ofs_rise_full = `OFS_PORTA_RISE + `PORT_STRIDE * p;
            wire [31:0] ofs_fall_full = `OFS_PORTA_FALL + `PORT_STRIDE * p;
            wire [31:0] ofs_flags_full = `OFS_PORTA_FLAGS + `PORT_STRIDE * p;
            wire [ADDR_WIDTH-1:0] ofs_rise = ofs_rise_full[ADDR_WIDTH-1:0];
            wire [ADDR_WIDTH-1:0] ofs_fall = ofs_fall_full[ADDR_WIDTH-1:0];
            wire [ADDR_WIDTH-1:0] ofs_flags = ofs_flags_full[ADDR_WIDTH-1:0];
            wire [PORT_WIDTH-1:0] hit = edge_hit[p*PORT_WIDTH +: PORT_WIDTH];
            wire [PORT_WIDTH-1:0] wbyte = w_data[PORT_WIDTH-1:0];
            always @(posedge i_clk) begin
                if (i_rst) begin
                    rise_enable[p*PORT_WIDTH +: PORT_WIDTH] <= `RST_BYTE;
                    fall_enable[p*PORT_WIDTH +: PORT_WIDTH] <= `RST_BYTE;
                    change_flags[p*PORT_WIDTH +: PORT_WIDTH] <= `RST_BYTE;
                end else begin
                    if (do_wr && wa == ofs_rise) begin
                        rise_enable[p*PORT_WIDTH +: PORT_WIDTH] <= wbyte;
                    end
                    if (do_wr && wa == ofs_fall) begin
                        fall_enable[p*PORT_WIDTH +: PORT_WIDTH] <= wbyte;
                    end
                    // new edges override the written value so none is lost
                    if (do_wr && wa == ofs_flags) begin
                        change_flags[p*PORT_WIDTH +: PORT_WIDTH] <= wbyte | hit;
                    end else begin
                        change_flags[p*PORT_WIDTH +: PORT_WIDTH] <=
                            change_flags[p*PORT_WIDTH +: PORT_WIDTH] | hit;
                    end
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // control, summary, interrupt, wake
    // ----------------------------------------
    wire summary_now = |change_flags;
    wire summary_rise = summary_now && !o_pin_change_summary_flag;

    always @(posedge i_clk) begin
        if (i_rst) begin
            pin_change_master_enable <= `RST_BIT;
            sleep_mode <= `RST_BIT;
            irq_status <= `RST_BIT;
            irq_mask <= `RST_BIT;
            o_pin_change_summary_flag <= 1'b0;
            o_irq <= 1'b0;
            o_wake <= 1'b0;
        end else begin
            o_pin_change_summary_flag <= summary_now;
            if (do_wr && wa == `OFS_CONTROL) begin
                pin_change_master_enable <= w_data[`CTRL_MASTER_EN_BIT];
            end
            if (do_wr && wa == `OFS_IRQ_MASK) begin
                irq_mask <= w_data[`STAT_SUMMARY_BIT];
            end
            // a new summary event wins over a write-one clear
            if (summary_rise) begin
                irq_status <= 1'b1;
            end else if (do_wr && wa == `OFS_IRQ_STATUS && w_data[`STAT_SUMMARY_BIT]) begin
                irq_status <= 1'b0;
            end
            // flags already hold the edge one cycle before wake rises
            if (sleep_mode && pin_change_master_enable && summary_now) begin
                sleep_mode <= 1'b0;
            end else if (do_wr && wa == `OFS_CONTROL) begin
                sleep_mode <= w_data[`CTRL_SLEEP_BIT];
            end
            o_wake <= sleep_mode && pin_change_master_enable && summary_now;
            o_irq <= pin_change_master_enable && summary_now && irq_mask;
        end
    end

    // ----------------------------------------
    // axi4-lite read path
    // ----------------------------------------
    reg [31:0] rd_word;
    reg rd_map;
    always @* begin
        rd_word = 32'h00000000;
        rd_map = (i_s_axi_araddr[1:0] == `ADDR_LO_ZERO);
        case (i_s_axi_araddr)
            `OFS_PORTA_RISE: rd_word[PORT_WIDTH-1:0] = rise_enable[PORT_WIDTH-1:0];
            `OFS_PORTA_FALL: rd_word[PORT_WIDTH-1:0] = fall_enable[PORT_WIDTH-1:0];
            `OFS_PORTA_FLAGS: rd_word[PORT_WIDTH-1:0] = change_flags[PORT_WIDTH-1:0];
            `OFS_PORTB_RISE: rd_word[PORT_WIDTH-1:0] = rise_enable[2*PORT_WIDTH-1:PORT_WIDTH];
            `OFS_PORTB_FALL: rd_word[PORT_WIDTH-1:0] = fall_enable[2*PORT_WIDTH-1:PORT_WIDTH];
            `OFS_PORTB_FLAGS: rd_word[PORT_WIDTH-1:0] = change_flags[2*PORT_WIDTH-1:PORT_WIDTH];
            `OFS_PORTC_RISE: rd_word[PORT_WIDTH-1:0] = rise_enable[NPIN-1:2*PORT_WIDTH];
            `OFS_PORTC_FALL: rd_word[PORT_WIDTH-1:0] = fall_enable[NPIN-1:2*PORT_WIDTH];
            `OFS_PORTC_FLAGS: rd_word[PORT_WIDTH-1:0] = change_flags[NPIN-1:2*PORT_WIDTH];
            `OFS_CONTROL: begin
                rd_word[`CTRL_MASTER_EN_BIT] = pin_change_master_enable;
                rd_word[`CTRL_SLEEP_BIT] = sleep_mode;
            end
            `OFS_IRQ_STATUS: rd_word[`STAT_SUMMARY_BIT] = irq_status;
            `OFS_IRQ_MASK: rd_word[`STAT_SUMMARY_BIT] = irq_mask;
            default: rd_map = 1'b0;
        endcase
    end

    always @(posedge i_clk) begin
        if (i_rst) begin
            o_s_axi_arready <= 1'b0;
            o_s_axi_rvalid <= 1'b0;
            o_s_axi_rdata <= 32'h00000000;
            o_s_axi_rresp <= `RESP_OKAY;
        end else begin
            o_s_axi_arready <= !o_s_axi_rvalid && !(i_s_axi_arvalid && o_s_axi_arready);
            if (i_s_axi_arvalid && o_s_axi_arready) begin
                o_s_axi_rvalid <= 1'b1;
                o_s_axi_rdata <= rd_map ? rd_word : 32'h00000000;
                o_s_axi_rresp <= rd_map ? `RESP_OKAY : `RESP_SLVERR;
            end else if (o_s_axi_rvalid && i_s_axi_rready) begin
                o_s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // pin_change_edge_interrupt

`default_nettype wire

/* sim/pin_change_edge_interrupt_assertions.sv */
/* Port checker for the pin-change interrupt block.
   Assumes one clock, synchronous active-high reset, bound to every instance. */
`timescale 1ns/1ns
`default_nettype none
module pin_change_checks (
    // clock and reset
    input wire i_clk,
    input wire i_rst,
    // pins and bus handshakes
    input wire [7:0] i_porta_pin,
    input wire [7:0] i_portb_pin,
    input wire [7:0] i_portc_pin,
    input wire i_s_axi_arvalid,
    input wire o_s_axi_arready,
    input wire o_s_axi_rvalid,
    input wire i_s_axi_rready,
    input wire o_s_axi_bvalid,
    input wire i_s_axi_bready,
    // interrupt side
    input wire o_irq,
    input wire o_pin_change_summary_flag,
    input wire o_wake
);
    logic [3:0] quiet;
    logic [23:0] last;
    wire [23:0] pins = {i_portc_pin, i_portb_pin, i_porta_pin};
    // cycles since any pin moved or a write landed; saturates
    always @(posedge i_clk) begin
        quiet <= (i_rst || o_s_axi_bvalid || pins != last) ? 4'h0 : quiet + {3'h0, quiet != 4'hF};
        last <= pins;
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    AST_RST_CLEAR: assert property (disable iff (1'b0) i_rst |=> !o_irq && !o_wake && !o_pin_change_summary_flag)
        else $error("outputs not cleared by reset");
    AST_IRQ_NEEDS_FLAG: assert property (o_irq |-> o_pin_change_summary_flag)
        else $error("interrupt without a flag");
    AST_WAKE_NEEDS_FLAG: assert property (o_wake |-> o_pin_change_summary_flag || $past(o_pin_change_summary_flag))
        else $error("wake without a recorded edge");
    AST_WAKE_PULSE: assert property (o_wake |=> !o_wake)
        else $error("wake longer than one cycle");
    AST_NO_SPURIOUS: assert property ($rose(o_pin_change_summary_flag) |-> quiet < 4'h4)
        else $error("summary rose with no cause");
    AST_READ_ANSWER: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid && !o_s_axi_arready)
        else $error("read answer late");
    AST_RVALID_HOLD: assert property (o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid)
        else $error("read data dropped");
    AST_BVALID_HOLD: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid)
        else $error("write response dropped");
    COV_WAKE: cover property (o_wake);
    COV_IRQ: cover property (o_irq);
    COV_SUMMARY: cover property ($rose(o_pin_change_summary_flag));
endmodule // pin_change_checks
bind pin_change_edge_interrupt pin_change_checks chk (.i_clk(i_clk), .i_rst(i_rst),
    .i_porta_pin(i_porta_pin), .i_portb_pin(i_portb_pin), .i_portc_pin(i_portc_pin),
    .i_s_axi_arvalid(i_s_axi_arvalid), .o_s_axi_arready(o_s_axi_arready),
    .o_s_axi_rvalid(o_s_axi_rvalid), .i_s_axi_rready(i_s_axi_rready),
    .o_s_axi_bvalid(o_s_axi_bvalid), .i_s_axi_bready(i_s_axi_bready), .o_irq(o_irq),
    .o_pin_change_summary_flag(o_pin_change_summary_flag), .o_wake(o_wake));
`default_nettype wire

/* sim/pin_source.sv */
/* External pin model for three 8-bit ports.
   Assumes pins move only right after a rising edge of the block clock. */
`timescale 1ns/1ns
`default_nettype none
module pin_source (
    // clock
    input wire logic i_clk,
    // pins
    output logic [7:0] o_porta_pin,
    output logic [7:0] o_portb_pin,
    output logic [7:0] o_portc_pin
);
    initial begin
        o_porta_pin = 8'h00;
        o_portb_pin = 8'h00;
        o_portc_pin = 8'h00;
    end
    // levels are held whole cycles: the block has no synchroniser of its own
    task automatic drive(input int p, input logic [7:0] v);
        @(posedge i_clk);
        case (p)
            0: o_porta_pin <= v;
            1: o_portb_pin <= v;
            default: o_portc_pin <= v;
        endcase
    endtask
endmodule // pin_source
`default_nettype wire

/* sim/pin_change_edge_interrupt_test.sv */
/* Self-checking bench for the pin-change interrupt block.
   Assumes the constants header and the pin model are compiled alongside. */
`timescale 1ns/1ns
`default_nettype none
`include "pin_change_consts.vh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("mismatch at %0t: got %h want %h", $time, got, exp); end end
module pin_change_edge_interrupt_test;
    logic i_clk = 1'b0, i_rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rd;
    logic [1:0] rs;
    wire [7:0] pa, pb, pc;
    wire awready, wready, bvalid, arready, rvalid, irq, summary, wake;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    int error_cnt = 0, checks = 0, cycles = 0;
    pin_source pins (.i_clk(i_clk), .o_porta_pin(pa), .o_portb_pin(pb), .o_portc_pin(pc));
    pin_change_edge_interrupt dut (.i_clk(i_clk), .i_rst(i_rst), .i_porta_pin(pa),
        .i_portb_pin(pb), .i_portc_pin(pc), .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
        .o_s_axi_awready(awready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF),
        .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
        .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .i_s_axi_araddr(araddr),
        .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
        .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .o_irq(irq),
        .o_pin_change_summary_flag(summary), .o_wake(wake));
    initial forever #20 i_clk = ~i_clk;
    // ------------------------------------------------------------
    // bus tasks and closing
    // ------------------------------------------------------------
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            conclude();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, 24'h0, d, 3'b111};
        // each channel released on its own handshake
        do begin
            @(posedge i_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        rs = bresp;
        bready <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a);
        @(posedge i_clk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do begin
            @(posedge i_clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        {rd, rs} = {rdata, rresp};
        rready <= 1'b0;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        for (int a = 0; a <= 'h2C; a += 4) begin
            rdr(8'(a));
            `CHK(rd, 32'h0)
        end
        rdr(8'h30);
        `CHK(rs, `RESP_SLVERR)
        `CHK(irq, 1'b0)
    endtask
    // bits 4 and 5 have both edges enabled, bits 2, 3, 6 and 7 only one, bits 0 and 1 none
    task automatic t_edges;
        logic [7:0] b;
        for (int p = 0; p < 3; p++) begin
            b = 8'(p * 12);
            wr(b, 8'h3C);
            wr(b + 8'h04, 8'hF0);
            rdr(b);
            `CHK(rd, 32'h3C)
            rdr(b + 8'h04);
            `CHK(rd, 32'hF0)
            pins.drive(p, 8'hFF);
            repeat (4) @(posedge i_clk);
            rdr(b + 8'h08);
            `CHK(rd, 32'h3C)
            `CHK(summary, 1'b1)
            `CHK(irq, 1'b0)
            wr(b + 8'h08, 8'h00);
            repeat (4) @(posedge i_clk);
            rdr(b + 8'h08);
            `CHK(rd, 32'h0)
            `CHK(summary, 1'b0)
            pins.drive(p, 8'h00);
            repeat (4) @(posedge i_clk);
            rdr(b + 8'h08);
            `CHK(rd, 32'hF0)
            wr(b + 8'h08, 8'h00);
        end
    endtask
    task automatic t_irq;
        wr(`OFS_IRQ_MASK, 8'h01);
        wr(`OFS_CONTROL, 8'h01);
        pins.drive(1, 8'hFF);
        repeat (4) @(posedge i_clk);
        `CHK(irq, 1'b1)
        rdr(`OFS_IRQ_STATUS);
        `CHK(rd, 32'h1)
        wr(`OFS_IRQ_MASK, 8'h00);
        repeat (2) @(posedge i_clk);
        `CHK(irq, 1'b0)
        wr(`OFS_IRQ_STATUS, 8'h01);
        rdr(`OFS_IRQ_STATUS);
        `CHK(rd, 32'h0)
        wr(`OFS_PORTB_FLAGS, 8'h00);
        wr(`OFS_IRQ_MASK, 8'h01);
        repeat (2) @(posedge i_clk);
        `CHK(irq, 1'b0)
    endtask
    task automatic t_sleep;
        int n;
        wr(`OFS_CONTROL, 8'h03);
        pins.drive(1, 8'h00);
        n = 0;
        while (!wake && n < 10) begin
            @(posedge i_clk);
            n++;
        end
        `CHK(wake, 1'b1)
        `CHK(summary, 1'b1)
        rdr(`OFS_PORTB_FLAGS);
        `CHK(rd, 32'hF0)
        rdr(`OFS_CONTROL);
        `CHK(rd, 32'h1)
        wr(`OFS_PORTB_FLAGS, 8'h00);
    endtask
    // the pin edge is timed to meet the clearing write
    task automatic t_race;
        fork
            begin
                wr(`OFS_PORTA_FLAGS, 8'h00);
                `CHK(rs, `RESP_OKAY)
            end
            begin
                @(posedge i_clk);
                pins.drive(0, 8'hFF);
            end
        join
        repeat (3) @(posedge i_clk);
        rdr(`OFS_PORTA_FLAGS);
        `CHK(rd, 32'h3C)
    endtask
    initial begin
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        t_reset();
        t_edges();
        t_irq();
        t_sleep();
        t_race();
        conclude();
    end
endmodule // pin_change_edge_interrupt_test
`default_nettype wire
